// >>> src/fzt_top.sv
/*
  Zone threshold registers, per-zone fan decisions, the enabled-fans-full safety
  override and the XOR tree test mode.
  Assumes an SMBus slave engine outside hands over byte reads and writes, and that
  the global lock bit lives in the configuration register outside this block.
  Zone n steers PWM n.
  Assumes the range codes, minimum duties, mode selects and manual duties come from
  registers held elsewhere and stay steady between host writes.
  Every output is registered, so duties, the override flag and read data appear one
  clock after the inputs or the strobe that cause them.
  Limitation: the override has no latch of its own; it falls away one clock after the
  last breach clears, and any slow ramp-down is left to logic further along.
*/
`timescale 1ns/1ns
module fzt_top #(
  // Number of zones; the register map only has room for three.
  parameter int NZONE = 3
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr_en,
  input wire logic [7:0] i_reg_wr_data,
  input wire logic i_reg_rd_en,
  input wire logic i_lock,
  input wire logic [NZONE-1:0][7:0] i_zone_temp,
  input wire logic [NZONE-1:0][3:0] i_zone_range,
  input wire logic [NZONE-1:0][7:0] i_min_duty,
  input wire logic [NZONE-1:0] i_below_limit_min_select,
  input wire logic [NZONE-1:0] i_pwm_auto,
  input wire logic [NZONE-1:0] i_pwm_disabled,
  input wire logic [NZONE-1:0][7:0] i_manual_duty,
  input wire logic [4:0] i_voltage_id_inputs,
  input wire logic [3:0] i_tachometer_inputs,
  input wire logic [1:0] i_pwm23_pin_in,
  output logic [7:0] o_reg_rd_data,
  output logic [NZONE-1:0][7:0] o_pwm_duty,
  output logic o_full_speed,
  output logic o_xor_tree_test_on,
  output logic o_xor_out
);
  // The register set and outputs all live in one state record.
  typedef struct packed {
    // Low temperature limit per zone, signed degrees.
    logic [NZONE-1:0][7:0] low_limit;
    // Absolute limit per zone, signed degrees.
    logic [NZONE-1:0][7:0] abs_limit;
    // Shared hysteresis register of zones 1 and 2.
    logic [7:0] hyst12;
    // Hysteresis register of zone 3; only the upper nibble is kept.
    logic [7:0] hyst3;
    // Test register; only the enable bit is kept.
    logic [7:0] xor_ctl;
    // Read data captured on a read strobe.
    logic [7:0] rd_data;
    // Registered duty per PWM output.
    logic [NZONE-1:0][7:0] duty;
    // Registered safety override flag.
    logic full_speed;
    // Registered parity of the tree inputs.
    logic xor_out;
  } fzt_top_state_t;

  // Registered state and its next value.
  fzt_top_state_t st_r;
  fzt_top_state_t st_nxt;
  // Per-zone results of the decision slices.
  logic [NZONE-1:0] breach;
  logic [NZONE-1:0][7:0] zone_duty;
  // Hysteresis nibble of each zone, unpacked from the two registers.
  logic [NZONE-1:0][3:0] hyst;
  // Test mode bit and the write strobe gated by the lock.
  logic xor_tree_test_on;
  logic wr_ok;

  // The hysteresis register layout is fixed for three zones, so other counts are refused
  // while the design is elaborated rather than left to misbehave later.
  if (NZONE != 3) begin : g_bad_nzone
    $error("fzt_top supports exactly three zones");
  end

  // Nibble unpacking of the two hysteresis registers.
  // Zone 1 sits in the upper nibble of the shared register.
  assign hyst[0] = st_r.hyst12[fzt_pkg::HYST_HI_LSB +: 4];
  // Zone 2 sits in the lower nibble of the same register.
  assign hyst[1] = st_r.hyst12[fzt_pkg::HYST_LO_LSB +: 4];
  // Zone 3 has a register of its own; its lower nibble is reserved.
  assign hyst[2] = st_r.hyst3[fzt_pkg::HYST_HI_LSB +: 4];

  // Test mode follows the stored enable bit, not the write strobe.
  assign xor_tree_test_on = st_r.xor_ctl[fzt_pkg::XOR_ON_BIT];
  // Writes are dropped while locked, so a locked part keeps its limits.
  // The lock is a level from outside; reads stay open while it is set.
  assign wr_ok = i_reg_wr_en && !i_lock;

  // One zone decision slice per zone.
  // Each slice keeps its own fan-on latch; the override decision is made here
  // because a breach in one zone reaches every enabled output.
  for (genvar z = 0; z < NZONE; z++) begin : g_zone
    fzt_zone u_zone (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      .i_temp(i_zone_temp[z]),
      .i_low_limit(st_r.low_limit[z]),
      .i_abs_limit(st_r.abs_limit[z]),
      .i_hyst(hyst[z]),
      .i_range(i_zone_range[z]),
      .i_min_duty(i_min_duty[z]),
      .i_min_select(i_below_limit_min_select[z]),
      .o_breach(breach[z]),
      .o_duty(zone_duty[z])
    );
  end

  // Register writes, read mux, duty selection and the XOR tree.
  always_comb begin
    // Everything holds unless a branch below changes it.
    st_nxt = st_r;

    // Register writes; reserved bits are masked so they always read as zero.
    if (wr_ok) begin
      unique case (i_reg_addr)
        // Low temperature limits.
        fzt_pkg::ADDR_LOW1: st_nxt.low_limit[0] = i_reg_wr_data;
        fzt_pkg::ADDR_LOW2: st_nxt.low_limit[1] = i_reg_wr_data;
        fzt_pkg::ADDR_LOW3: st_nxt.low_limit[2] = i_reg_wr_data;
        // Absolute limits.
        fzt_pkg::ADDR_ABS1: st_nxt.abs_limit[0] = i_reg_wr_data;
        fzt_pkg::ADDR_ABS2: st_nxt.abs_limit[1] = i_reg_wr_data;
        fzt_pkg::ADDR_ABS3: st_nxt.abs_limit[2] = i_reg_wr_data;
        // Hysteresis registers; zone 3 keeps only its upper nibble.
        fzt_pkg::ADDR_HYST12: st_nxt.hyst12 = i_reg_wr_data;
        fzt_pkg::ADDR_HYST3: st_nxt.hyst3 = i_reg_wr_data & fzt_pkg::MASK_HYST3;
        // Test register; only the enable bit exists.
        fzt_pkg::ADDR_XOR: st_nxt.xor_ctl = i_reg_wr_data & fzt_pkg::MASK_XOR;
        default: st_nxt.xor_ctl = st_r.xor_ctl; // Other addresses belong elsewhere.
      endcase
    end

    // Read data is captured when asked for; unmapped offsets return zero.
    // A read and a write in the same cycle return the old value, since both use st_r.
    if (i_reg_rd_en) begin
      unique case (i_reg_addr)
        // Low temperature limits.
        fzt_pkg::ADDR_LOW1: st_nxt.rd_data = st_r.low_limit[0];
        fzt_pkg::ADDR_LOW2: st_nxt.rd_data = st_r.low_limit[1];
        fzt_pkg::ADDR_LOW3: st_nxt.rd_data = st_r.low_limit[2];
        // Absolute limits.
        fzt_pkg::ADDR_ABS1: st_nxt.rd_data = st_r.abs_limit[0];
        fzt_pkg::ADDR_ABS2: st_nxt.rd_data = st_r.abs_limit[1];
        fzt_pkg::ADDR_ABS3: st_nxt.rd_data = st_r.abs_limit[2];
        // Hysteresis registers, reserved bits already held at zero.
        fzt_pkg::ADDR_HYST12: st_nxt.rd_data = st_r.hyst12;
        fzt_pkg::ADDR_HYST3: st_nxt.rd_data = st_r.hyst3;
        // Test register.
        fzt_pkg::ADDR_XOR: st_nxt.rd_data = st_r.xor_ctl;
        default: st_nxt.rd_data = 8'h00;
      endcase
    end

    // Any breach, from any zone even one without a fan, forces every enabled fan full,
    // but only while at least one fan runs automatically.
    // A zone whose limit is coded as the off value never reports a breach.
    st_nxt.full_speed = (|breach) && (|i_pwm_auto);
    // Per-output duty, in order of precedence.
    for (int p = 0; p < NZONE; p++) begin
      if (i_pwm_disabled[p]) begin
        // A disabled output stays at zero, even under the override.
        st_nxt.duty[p] = fzt_pkg::DUTY_ZERO;
      end else if (st_nxt.full_speed) begin
        // Safety override, manual outputs included.
        st_nxt.duty[p] = fzt_pkg::DUTY_FULL;
      end else if (i_pwm_auto[p]) begin
        // Automatic mode follows the zone that steers this output.
        st_nxt.duty[p] = zone_duty[p];
      end else begin
        // Manual mode passes the host's duty straight through.
        st_nxt.duty[p] = i_manual_duty[p];
      end
    end

    // The tree only answers in test mode so normal operation sees a quiet pin.
    // The order of the inputs does not matter for a parity tree.
    // The two PWM pins are fed back from their pads, so a tester sees those pins too.
    if (xor_tree_test_on) begin
      st_nxt.xor_out = ^{i_voltage_id_inputs, i_tachometer_inputs, i_pwm23_pin_in};
    end else begin
      st_nxt.xor_out = 1'b0;
    end
  end

  // State register with the power-on register values.
  // Reset is synchronous, so a glitch between edges cannot disturb the registers.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      // Limits and hysteresis come up at their power-on values.
      st_r.low_limit <= {NZONE{fzt_pkg::RST_LOW}};
      st_r.abs_limit <= {NZONE{fzt_pkg::RST_ABS}};
      st_r.hyst12 <= fzt_pkg::RST_HYST12;
      st_r.hyst3 <= fzt_pkg::RST_HYST3;
      // Test mode starts off so a fresh part behaves normally.
      st_r.xor_ctl <= fzt_pkg::RST_XOR;
      // Read data and outputs start quiet; every fan output starts at zero duty.
      st_r.rd_data <= 8'h00;
      st_r.duty <= '0;
      st_r.full_speed <= 1'b0;
      st_r.xor_out <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state flip-flops.
  // No output passes through logic after its flip-flop, so nothing glitches at the pins.
  assign o_reg_rd_data = st_r.rd_data;
  assign o_pwm_duty = st_r.duty;
  // The override flag lets logic outside see why every enabled fan is running full.
  assign o_full_speed = st_r.full_speed;
  // The test bit is shown as stored, the same bit that gates the tree.
  assign o_xor_tree_test_on = st_r.xor_ctl[fzt_pkg::XOR_ON_BIT];
  assign o_xor_out = st_r.xor_out;
endmodule

// >>> shared/fzt_pkg.sv
/*
  Shared constants of the fan zone threshold logic: register offsets, reset values,
  field positions, special limit codes and the temperature range lookup.
  Assumes the SMBus slave engine outside presents decoded byte accesses to the block.
*/
package fzt_pkg;
  // Register offsets.
  localparam logic [7:0] ADDR_LOW1 = 8'h67;
  localparam logic [7:0] ADDR_LOW2 = 8'h68;
  localparam logic [7:0] ADDR_LOW3 = 8'h69;
  localparam logic [7:0] ADDR_ABS1 = 8'h6a;
  localparam logic [7:0] ADDR_ABS2 = 8'h6b;
  localparam logic [7:0] ADDR_ABS3 = 8'h6c;
  localparam logic [7:0] ADDR_HYST12 = 8'h6d;
  localparam logic [7:0] ADDR_HYST3 = 8'h6e;
  localparam logic [7:0] ADDR_XOR = 8'h6f;
  // Reset values.
  localparam logic [7:0] RST_LOW = 8'h5a;
  localparam logic [7:0] RST_ABS = 8'h64;
  localparam logic [7:0] RST_HYST12 = 8'h44;
  localparam logic [7:0] RST_HYST3 = 8'h40;
  localparam logic [7:0] RST_XOR = 8'h00;
  // Writable bits: the low nibble of the zone 3 register and bits 7:1 of the test register are reserved.
  localparam logic [7:0] MASK_HYST3 = 8'hf0;
  localparam logic [7:0] MASK_XOR = 8'h01;
  // Field positions.
  localparam int HYST_HI_LSB = 4;
  localparam int HYST_LO_LSB = 0;
  localparam int XOR_ON_BIT = 0;
  // Special codes.
  localparam logic [7:0] ABS_OFF_CODE = 8'h80;
  localparam logic [7:0] DUTY_FULL = 8'hff;
  localparam logic [7:0] DUTY_ZERO = 8'h00;
  // Degrees at which the ramp reaches full, per range code; fractions rounded up.
  localparam logic [15:0][7:0] RANGE_DEG = {
    8'h50, 8'h36, 8'h28, 8'h20, 8'h1b, 8'h14, 8'h10, 8'h0e,
    8'h0a, 8'h08, 8'h07, 8'h05, 8'h04, 8'h04, 8'h03, 8'h02};
endpackage

// >>> src/fzt_zone.sv
/*
  One temperature zone: hysteresis latch of the fan-on state, absolute limit test
  and automatic duty calculation.
  Assumes temperature, limits and minimum duty are stable inputs sampled on i_clk.
*/
`timescale 1ns/1ns
module fzt_zone (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_temp,
  input wire logic [7:0] i_low_limit,
  input wire logic [7:0] i_abs_limit,
  input wire logic [3:0] i_hyst,
  input wire logic [3:0] i_range,
  input wire logic [7:0] i_min_duty,
  input wire logic i_min_select,
  output logic o_breach,
  output logic [7:0] o_duty
);
  // The only state is whether the fan is running.
  typedef struct packed {
    logic fan_on;
  } fzt_zone_state_t;

  fzt_zone_state_t st_r;
  fzt_zone_state_t st_nxt;
  logic signed [9:0] temp_s;
  logic signed [9:0] low_s;
  logic signed [9:0] off_level;
  logic [7:0] delta;
  logic [7:0] span;
  logic [15:0] ramp;

  // Signed arithmetic in ten bits so limit minus hysteresis cannot wrap.
  assign temp_s = 10'(signed'(i_temp));
  assign low_s = 10'(signed'(i_low_limit));
  assign off_level = low_s - 10'(signed'({1'b0, i_hyst}));

  // Fan-on latch, duty and breach decision.
  always_comb begin
    st_nxt = st_r;
    delta = 8'(temp_s - low_s);
    span = 8'(fzt_pkg::DUTY_FULL - i_min_duty);
    ramp = 16'(span * delta) / 16'(fzt_pkg::RANGE_DEG[i_range]);
    if (temp_s >= low_s) begin
      st_nxt.fan_on = 1'b1;
    end else if (temp_s < off_level) begin
      st_nxt.fan_on = 1'b0;
    end
    if (temp_s >= low_s) begin
      // Duty climbs from the minimum and saturates once the range is covered.
      if (delta >= fzt_pkg::RANGE_DEG[i_range]) begin
        o_duty = fzt_pkg::DUTY_FULL;
      end else begin
        o_duty = 8'(i_min_duty + ramp[7:0]);
      end
    end else if (st_r.fan_on && temp_s >= off_level) begin
      o_duty = i_min_duty;
    end else begin
      o_duty = i_min_select ? i_min_duty : fzt_pkg::DUTY_ZERO;
    end
    // A limit coded as minus 128 never trips.
    o_breach = (i_abs_limit != fzt_pkg::ABS_OFF_CODE) &&
               (temp_s > 10'(signed'(i_abs_limit)));
  end

  // State register.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// >>> tb/fzt_host.sv
/* Host model: single byte register writes and reads on the decoded bus.
   Assumes inputs move 1 ns after i_clk rises. */
`timescale 1ns/1ns
module fzt_host (
  input wire logic i_clk,
  input wire logic [7:0] o_reg_rd_data,
  output logic [7:0] i_reg_addr,
  output logic i_reg_wr_en,
  output logic [7:0] i_reg_wr_data,
  output logic i_reg_rd_en
);
  initial begin
    i_reg_addr = 8'h00;
    i_reg_wr_en = 1'b0;
    i_reg_wr_data = 8'h00;
    i_reg_rd_en = 1'b0;
  end
  // Write strobe held over one sampling edge; stale data is inverted so nothing leans on it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk) #1;
    i_reg_addr = a;
    i_reg_wr_data = d;
    i_reg_wr_en = 1'b1;
    @(posedge i_clk) #1;
    i_reg_wr_en = 1'b0;
    i_reg_wr_data = ~d;
  endtask
  // Read strobe for one edge; data is taken once that edge has landed.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk) #1;
    i_reg_addr = a;
    i_reg_rd_en = 1'b1;
    @(posedge i_clk) #1;
    i_reg_rd_en = 1'b0;
    d = o_reg_rd_data;
  endtask
endmodule

// >>> tb/fzt_top_asserts.sv
/* Port checker for fzt_top.
   Assumes it is bound into every fzt_top instance. */
`timescale 1ns/1ns
module fzt_top_asserts #(parameter int NZONE = 3) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr_en,
  input wire logic [7:0] i_reg_wr_data,
  input wire logic i_reg_rd_en,
  input wire logic i_lock,
  input wire logic [NZONE-1:0] i_pwm_auto,
  input wire logic [NZONE-1:0] i_pwm_disabled,
  input wire logic [NZONE-1:0][7:0] i_manual_duty,
  input wire logic [4:0] i_voltage_id_inputs,
  input wire logic [3:0] i_tachometer_inputs,
  input wire logic [1:0] i_pwm23_pin_in,
  input wire logic [7:0] o_reg_rd_data,
  input wire logic [NZONE-1:0][7:0] o_pwm_duty,
  input wire logic o_full_speed,
  input wire logic o_xor_tree_test_on,
  input wire logic o_xor_out
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Test register accesses, open and locked.
  sequence xor_wr_s; i_reg_wr_en && !i_lock && i_reg_addr == 8'h6f; endsequence
  sequence lock_wr_s; i_reg_wr_en && i_lock && i_reg_addr == 8'h6f; endsequence
  sequence xor_rd_s; i_reg_rd_en && i_reg_addr == 8'h6f; endsequence
  lock_hold_a: assert property (lock_wr_s |=> $stable(o_xor_tree_test_on))
    else $error("locked write changed test bit");
  xor_enable_a: assert property (xor_wr_s |=> o_xor_tree_test_on == $past(i_reg_wr_data[0]))
    else $error("test bit not written");
  xor_tree_a: assert property ((o_xor_tree_test_on && !(i_reg_wr_en && i_reg_addr == 8'h6f)) |=>
    o_xor_out == $past(^{i_voltage_id_inputs, i_tachometer_inputs, i_pwm23_pin_in}))
    else $error("tree output wrong");
  xor_idle_a: assert property ((!o_xor_tree_test_on && !(i_reg_wr_en && i_reg_addr == 8'h6f)) |=> !o_xor_out)
    else $error("tree output outside test mode");
  xor_read_a: assert property (xor_rd_s |=> o_reg_rd_data == {7'h00, $past(o_xor_tree_test_on)})
    else $error("test register read wrong");
  full_on_a: assert property (o_full_speed |-> o_pwm_duty[0] == ($past(i_pwm_disabled[0]) ? 8'h00 : 8'hff))
    else $error("override duty wrong");
  full_dis_a: assert property (i_pwm_disabled[2] |=> o_pwm_duty[2] == 8'h00)
    else $error("disabled output driven");
  manual_duty_a: assert property ((!i_pwm_auto[1] && !i_pwm_disabled[1]) |=>
    (o_full_speed ? o_pwm_duty[1] == 8'hff : o_pwm_duty[1] == $past(i_manual_duty[1])))
    else $error("manual duty wrong");
endmodule
bind fzt_top fzt_top_asserts #(.NZONE(NZONE)) u_chk (.*);

// >>> tb/test_fzt_top.sv
/* Self-checking bench for fzt_top with the host model on the register bus.
   Assumes the checker is bound in; inputs move 1 ns after i_clk rises. */
`timescale 1ns/1ns
module test_fzt_top;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_lock = 1'b0;
  logic [7:0] i_reg_addr, i_reg_wr_data, o_reg_rd_data, rd;
  logic i_reg_wr_en, i_reg_rd_en, o_full_speed, o_xor_tree_test_on, o_xor_out;
  logic [2:0][7:0] i_zone_temp = '0, i_min_duty = '0, i_manual_duty = '0, o_pwm_duty;
  logic [2:0][3:0] i_zone_range = '0;
  logic [2:0] i_below_limit_min_select = '0, i_pwm_auto = '0, i_pwm_disabled = '0;
  logic [4:0] i_voltage_id_inputs = '0;
  logic [3:0] i_tachometer_inputs = '0;
  logic [1:0] i_pwm23_pin_in = '0;
  int error_cnt = 0, cmp_count = 0;
  always #5 i_clk = ~i_clk;
  fzt_top dut (.*);
  fzt_host host (.*);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rd);
    chk(rd, e, "reg");
  endtask
  // Zone 1 temperature change, then the duty after the latch cycle has passed.
  task automatic temp(input logic [7:0] t, input logic [7:0] e);
    i_zone_temp[0] = t;
    step(3);
    chk(o_pwm_duty[0], e, "duty");
  endtask
  task automatic t_regs;
    logic [7:0] exp [9] = '{8'h5a, 8'h5a, 8'h5a, 8'h64, 8'h64, 8'h64, 8'h44, 8'h40, 8'h00};
    for (int k = 0; k < 9; k++) rdchk(8'h67 + 8'(k), exp[k]);
    host.wr(8'h6e, 8'hff);
    rdchk(8'h6e, 8'hf0);
    rdchk(8'h70, 8'h00);
    i_lock = 1'b1;
    host.wr(8'h67, 8'haa);
    host.wr(8'h6f, 8'h01);
    rdchk(8'h67, 8'h5a);
    rdchk(8'h6f, 8'h00);
    i_lock = 1'b0;
    $display("test regs done");
  endtask
  task automatic t_zone;
    host.wr(8'h6d, 8'h3c);
    // Start below limit minus hysteresis so the zone 1 fan latch stays off.
    i_zone_temp[0] = 8'hca;
    host.wr(8'h67, 8'hce);
    i_pwm_auto = 3'b001;
    i_min_duty[0] = 8'h40;
    temp(8'hcd, 8'h00);
    temp(8'hce, 8'h40);
    temp(8'hcf, 8'h9f);
    temp(8'hf0, 8'hff);
    temp(8'hcc, 8'h40);
    temp(8'hcb, 8'h40);
    temp(8'hca, 8'h00);
    i_below_limit_min_select[0] = 1'b1;
    temp(8'hca, 8'h40);
    $display("test zone done");
  endtask
  task automatic t_abs;
    i_manual_duty[1] = 8'h10;
    i_pwm_disabled[2] = 1'b1;
    i_zone_temp[2] = 8'h65;
    step(3);
    for (int k = 0; k < 3; k++) chk(o_pwm_duty[k], k == 2 ? 8'h00 : 8'hff, "full");
    // With no output in automatic mode the breach must not force anything.
    i_pwm_auto = 3'b000;
    step(3);
    chk({7'h00, o_full_speed}, 8'h00, "no auto");
    chk(o_pwm_duty[1], 8'h10, "no auto manual");
    i_pwm_auto = 3'b001;
    i_zone_temp[2] = 8'h64;
    step(3);
    chk(o_pwm_duty[1], 8'h10, "manual");
    host.wr(8'h6c, 8'h80);
    i_zone_temp[2] = 8'h7f;
    step(3);
    chk({7'h00, o_full_speed}, 8'h00, "off code");
    host.wr(8'h6c, 8'h7f);
    step(3);
    chk({7'h00, o_full_speed}, 8'h00, "max limit");
    $display("test abs done");
  endtask
  task automatic t_xor;
    logic [10:0] v = '0;
    host.wr(8'h6f, 8'h01);
    for (int k = 0; k < 11; k++) begin
      v[k] = 1'b1;
      {i_pwm23_pin_in, i_tachometer_inputs, i_voltage_id_inputs} = v;
      step(2);
      chk({7'h00, o_xor_out}, {7'h00, ^v}, "tree");
    end
    host.wr(8'h6f, 8'h00);
    step(2);
    chk({7'h00, o_xor_out}, 8'h00, "tree off");
    $display("test xor done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    step(5);
    i_reset_n = 1'b1;
    t_regs();
    t_zone();
    t_abs();
    t_xor();
    wrap_up();
  end
  // Hang guard, far beyond the 112 or so cycles the tests take.
  initial begin
    #50000;
    error_cnt++;
    wrap_up();
  end
endmodule
